/* File: include/run_ctl_pkg.sv */
// Constants and types shared by the run-control and debug interrupt block
package run_ctl_pkg;
   localparam int ADDR_W = 24;
   localparam int DATA_W = 64;
   localparam int OP_W = 2;
   // Register byte offsets
   localparam logic [ADDR_W-1:0] RUN_CTRL_OFS = 24'h104000;
   localparam logic [ADDR_W-1:0] DBG_FORCE_OFS = 24'h100088;
   // Field positions
   localparam int OP_LSB = 0;
   localparam int FORCE_BIT = 0;
   // Reset values
   localparam logic [DATA_W-1:0] DBG_FORCE_RST = 64'h0;
   localparam logic [DATA_W-1:0] POR_PC = 64'h0;
   localparam logic [DATA_W-1:0] RDATA_RST = 64'h0;
   // Debug interrupt priority, above every mask level
   localparam int PRIO_W = 5;
   localparam logic [PRIO_W-1:0] DBG_INT_PRIO = 5'h10;

   typedef enum logic [OP_W-1:0] {
      op_halt = 2'b00,
      op_continue = 2'b01,
      op_core_reset = 2'b10,
      op_device_debug_reset = 2'b11
   } op_t;

   // Read value of the operation field before any write
   localparam op_t OP_RST = op_continue;

   typedef enum logic [1:0] {
      st_run = 2'b00,
      st_drain = 2'b01,
      st_halted = 2'b10
   } run_state_t;
endpackage : run_ctl_pkg

/* File: include/run_ctl_if.sv */
// Carrier between the register front end and the run sequencer
`timescale 1ns/1ps
interface run_ctl_if;
   logic halt_req;
   logic cont_req;
   logic core_rst;
   logic boot_halt;
   logic fetch_stop;
   logic suspended;
   logic pc_zero_load;

   modport ctl (
      output halt_req,
      output cont_req,
      output core_rst,
      output boot_halt,
      input fetch_stop,
      input suspended,
      input pc_zero_load
   );
   modport seq (
      input halt_req,
      input cont_req,
      input core_rst,
      input boot_halt,
      output fetch_stop,
      output suspended,
      output pc_zero_load
   );
endinterface : run_ctl_if

/* File: rtl/core_run_sequencer.sv */
// Halt, drain and resume sequencing of the core
`timescale 1ns/1ps
module core_run_sequencer
   import run_ctl_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_pipe_drained,
   run_ctl_if.seq rc
);
   run_state_t state_ff;
   run_state_t nxt_state;
   logic boot_hold_ff;
   logic nxt_boot_hold;
   logic pc_zero_ff;
   logic stop_ff;
   logic halted_ff;
   logic resume;

   // Resume only leaves a stopped state
   assign resume = rc.cont_req && (state_ff != st_run);

   // Halt stops fetch, then waits for the drain
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         st_run:
         begin
            if (rc.boot_halt)
               nxt_state = st_halted;
            else if (rc.halt_req)
               nxt_state = st_drain;
         end
         st_drain:
         begin
            if (rc.cont_req)
               nxt_state = st_run;
            else if (i_pipe_drained)
               nxt_state = st_halted;
         end
         st_halted:
         begin
            if (rc.cont_req)
               nxt_state = st_run;
         end
         default: nxt_state = st_run;
      endcase
   end

   // Boot-suspended marker, dropped by any core reset
   assign nxt_boot_hold = rc.boot_halt ? 1'b1 :
      (rc.core_rst || resume) ? 1'b0 : boot_hold_ff;

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_ff <= st_run;
         boot_hold_ff <= 1'b0;
         pc_zero_ff <= 1'b0;
         stop_ff <= 1'b0;
         halted_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         // Status flags kept as flops so the top outputs are registered
         stop_ff <= (nxt_state != st_run);
         halted_ff <= (nxt_state == st_halted);
         boot_hold_ff <= nxt_boot_hold;
         pc_zero_ff <= resume && boot_hold_ff && !rc.core_rst;
      end
   end

   assign rc.fetch_stop = stop_ff;
   assign rc.suspended = halted_ff;
   assign rc.pc_zero_load = pc_zero_ff;

   // A drain only ends when the pipeline says so or a continue is written
   drain_wait_a: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      (state_ff == st_drain && !i_pipe_drained && !rc.cont_req)
      |=> state_ff == st_drain)
      else $error("halt completed before pipeline drained");

   // A halted core restarts on the next edge after continue
   resume_exit_a: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      (state_ff == st_halted && rc.cont_req) |=> state_ff == st_run)
      else $error("core did not resume after continue");
endmodule : core_run_sequencer

/* File: rtl/cpu_run_control_debug_int.sv */
// Debug run control and forced debug interrupt register block
`timescale 1ns/1ps
module cpu_run_control_debug_int
   import run_ctl_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // Memory-mapped register port
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [run_ctl_pkg::ADDR_W-1:0] i_addr,
   input wire logic [run_ctl_pkg::DATA_W-1:0] i_wdata,
   output logic [run_ctl_pkg::DATA_W-1:0] o_rdata,
   output logic o_rd_valid,
   // Core side
   input wire logic i_boot_halt,
   input wire logic i_pipe_drained,
   input wire logic i_debug_vector_select,
   input wire logic [run_ctl_pkg::DATA_W-1:0] i_debug_vector_address,
   input wire logic i_core_sleeping,
   input wire logic i_debug_int_block,
   input wire logic i_debug_int_clear,
   output logic o_fetch_stop,
   output logic o_halted_flag,
   output logic o_core_reset_event,
   output logic o_device_debug_reset_event,
   output logic o_vector_select,
   output logic [run_ctl_pkg::DATA_W-1:0] o_vector_address,
   output logic o_resume_pc_load,
   output logic [run_ctl_pkg::DATA_W-1:0] o_resume_pc,
   output logic o_forced_cause_set,
   output logic o_debug_int_req,
   output logic [run_ctl_pkg::PRIO_W-1:0] o_debug_int_prio,
   output logic o_wake_req
);
   import run_ctl_pkg::*;

   run_ctl_if rc ();

   op_t op_ff;
   op_t wr_op;
   logic hit_run;
   logic hit_force;
   logic wr_run;
   logic wr_force_one;
   logic strap_taken_ff;
   logic core_rst_ff;
   logic dbg_rst_ff;
   logic vec_sel_ff;
   logic [DATA_W-1:0] vec_addr_ff;
   logic vec_track;
   logic pending_ff;
   logic nxt_pending;
   logic force_accept;
   logic cause_ff;
   logic launch_ff;
   logic wake_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic [DATA_W-1:0] nxt_rdata;
   logic rd_valid_ff;

   // Address decode; reserved upper bits are simply not stored
   assign hit_run = (i_addr == RUN_CTRL_OFS);
   assign hit_force = (i_addr == DBG_FORCE_OFS);
   assign wr_run = i_wr_en && hit_run;
   assign wr_op = op_t'(i_wdata[OP_LSB +: OP_W]);
   assign wr_force_one = i_wr_en && hit_force && i_wdata[FORCE_BIT];

   // Operation decode towards the sequencer
   assign rc.halt_req = wr_run && (wr_op == op_halt);
   assign rc.cont_req = wr_run && (wr_op == op_continue);
   assign rc.core_rst = wr_run && (wr_op == op_core_reset);

   // Strap level sampled once, on the first edge after reset release
   assign rc.boot_halt = !strap_taken_ff && i_boot_halt;

   core_run_sequencer u_seq (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_pipe_drained(i_pipe_drained),
      .rc(rc)
   );

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         strap_taken_ff <= 1'b0;
      else
         strap_taken_ff <= 1'b1;
   end

   // Last written operation code; every write counts
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         op_ff <= OP_RST;
      else if (wr_run)
         op_ff <= wr_op;
   end

   // Reset events: core reset always fires, debug reset only on a change
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         core_rst_ff <= 1'b0;
         dbg_rst_ff <= 1'b0;
      end
      else
      begin
         core_rst_ff <= rc.core_rst;
         dbg_rst_ff <= wr_run && (wr_op == op_device_debug_reset)
            && (op_ff != op_device_debug_reset);
      end
   end

   // Vector setting follows its inputs while running, frozen when stopped;
   // a core reset reloads it so the tool's new PC takes hold
   assign vec_track = !rc.fetch_stop || rc.core_rst;

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         vec_sel_ff <= 1'b0;
         vec_addr_ff <= POR_PC;
      end
      else if (vec_track)
      begin
         vec_sel_ff <= i_debug_vector_select;
         vec_addr_ff <= i_debug_vector_address;
      end
   end

   // Forced debug interrupt: one pending event until the core clears it.
   // A new force in the clear cycle wins so the request is never lost.
   assign force_accept = wr_force_one &&
      (!pending_ff || i_debug_int_clear);
   assign nxt_pending = force_accept ? 1'b1 :
      i_debug_int_clear ? 1'b0 : pending_ff;

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         pending_ff <= DBG_FORCE_RST[FORCE_BIT];
         cause_ff <= 1'b0;
      end
      else
      begin
         pending_ff <= nxt_pending;
         cause_ff <= force_accept;
      end
   end

   // Launch waits out sleep (wake first) and any blocking condition
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         launch_ff <= 1'b0;
         wake_ff <= 1'b0;
      end
      else
      begin
         launch_ff <= nxt_pending && !i_core_sleeping
            && !i_debug_int_block;
         wake_ff <= nxt_pending && i_core_sleeping;
      end
   end

   // Read mux; the force bit reads zero, which is one legal value
   assign nxt_rdata = hit_run ?
      {{(DATA_W-OP_W){1'b0}}, op_ff} : RDATA_RST;

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         rdata_ff <= RDATA_RST;
         rd_valid_ff <= 1'b0;
      end
      else
      begin
         rd_valid_ff <= i_rd_en;
         if (i_rd_en)
            rdata_ff <= nxt_rdata;
      end
   end

   // Outputs, all from flip-flops except the constant resume PC and priority
   assign o_rdata = rdata_ff;
   assign o_rd_valid = rd_valid_ff;
   assign o_fetch_stop = rc.fetch_stop;
   assign o_halted_flag = rc.suspended;
   assign o_core_reset_event = core_rst_ff;
   assign o_device_debug_reset_event = dbg_rst_ff;
   assign o_vector_select = vec_sel_ff;
   assign o_vector_address = vec_addr_ff;
   assign o_resume_pc_load = rc.pc_zero_load;
   assign o_resume_pc = POR_PC;
   assign o_forced_cause_set = cause_ff;
   assign o_debug_int_req = launch_ff;
   assign o_debug_int_prio = DBG_INT_PRIO;
   assign o_wake_req = wake_ff;

   // Core reset code gives an event pulse one edge later, every time
   core_rst_pulse_a: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_wr_en && hit_run && i_wdata[1:0] == 2'b10)
      |=> o_core_reset_event)
      else $error("core reset write gave no event");

   // A second consecutive debug reset code is swallowed
   dbg_rst_repeat_a: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_wr_en && hit_run && i_wdata[1:0] == 2'b11
         && op_ff == op_device_debug_reset)
      |=> !o_device_debug_reset_event)
      else $error("repeated debug reset was not ignored");

   // Debug reset after a different code does fire
   dbg_rst_fresh_a: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_wr_en && hit_run && i_wdata[1:0] == 2'b11
         && op_ff != op_device_debug_reset)
      |=> o_device_debug_reset_event)
      else $error("debug reset after other code missed");

   // Read returns last written code with zero upper bits
   run_readback_a: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_wr_en && hit_run) ##1 (i_rd_en && hit_run && !i_wr_en)
      |=> o_rd_valid && o_rdata == {62'h0, $past(i_wdata[1:0], 2)})
      else $error("run control readback mismatch");

   // Halt code stops fetch on the next edge
   halt_stop_a: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_wr_en && hit_run && i_wdata[1:0] == 2'b00 && !o_fetch_stop)
      |=> o_fetch_stop && !o_halted_flag)
      else $error("halt did not stop fetching");

   // Halted flag only with fetch stopped
   halted_flag_a: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      o_halted_flag |-> o_fetch_stop)
      else $error("halted flag set while fetching");

   // Vector output frozen while stopped unless a core reset came
   vector_hold_a: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      (o_fetch_stop && !rc.core_rst)
      |=> $stable(o_vector_address) && $stable(o_vector_select))
      else $error("vector changed while suspended");

   // Accepted force raises cause and a pending request
   force_set_a: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_wr_en && hit_force && i_wdata[0] && !pending_ff)
      |=> o_forced_cause_set ##0 pending_ff)
      else $error("force write did not set cause");

   // Zero writes and repeats while pending give no new cause
   force_ignore_a: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      (pending_ff && !i_debug_int_clear) |=> !o_forced_cause_set)
      else $error("force repeated before clear");

   // A sleeping core gets a wake request, never the launch
   sleep_wake_a: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      (nxt_pending && i_core_sleeping) |=> o_wake_req && !o_debug_int_req)
      else $error("debug interrupt launched into sleep");

   // Priority sits above every mask level
   int_prio_a: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      o_debug_int_req |-> o_debug_int_prio == 5'h10)
      else $error("debug interrupt priority wrong");
endmodule : cpu_run_control_debug_int

/* File: verif/core_pipe_model.sv */
// Behavioural core pipeline that drains some cycles after a fetch stop
`timescale 1ns/1ps
module core_pipe_model
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_fetch_stop,
   input wire logic [3:0] i_drain_cycles,
   output logic o_pipe_drained
);
   logic [3:0] cnt_ff;

   // Drain time is set per halt, so prompt and slow drains both occur
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         cnt_ff <= 4'h0;
         o_pipe_drained <= 1'b0;
      end
      else if (!i_fetch_stop)
      begin
         cnt_ff <= 4'h0;
         o_pipe_drained <= 1'b0;
      end
      else if (cnt_ff >= i_drain_cycles)
         o_pipe_drained <= 1'b1;
      else
         cnt_ff <= cnt_ff + 4'h1;
   end
endmodule : core_pipe_model

/* File: verif/cpu_run_control_debug_int_bench.sv */
// Self-checking bench for the run control and debug interrupt block
`timescale 1ns/1ps
module cpu_run_control_debug_int_bench;
   import run_ctl_pkg::*;
   logic clk, rst, wr, rd, rvld, boot, drained, vsel, sleep, blk, clr;
   logic fstop, halted, crst, drst, ovsel, pcld, cause, ireq, wake;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, vaddr, ovaddr, rpc, v_old;
   logic [PRIO_W-1:0] prio;
   logic [3:0] dly;
   int failures, tests_run, op_m;
   bit boot_m;

   cpu_run_control_debug_int dut_u (.i_sys_clk(clk), .i_rst(rst),
      .i_wr_en(wr), .i_rd_en(rd), .i_addr(addr), .i_wdata(wdata),
      .o_rdata(rdata), .o_rd_valid(rvld), .i_boot_halt(boot),
      .i_pipe_drained(drained), .i_debug_vector_select(vsel),
      .i_debug_vector_address(vaddr), .i_core_sleeping(sleep),
      .i_debug_int_block(blk), .i_debug_int_clear(clr),
      .o_fetch_stop(fstop), .o_halted_flag(halted),
      .o_core_reset_event(crst), .o_device_debug_reset_event(drst),
      .o_vector_select(ovsel), .o_vector_address(ovaddr),
      .o_resume_pc_load(pcld), .o_resume_pc(rpc),
      .o_forced_cause_set(cause), .o_debug_int_req(ireq),
      .o_debug_int_prio(prio), .o_wake_req(wake));

   core_pipe_model pipe_u (.i_sys_clk(clk), .i_rst(rst),
      .i_fetch_stop(fstop), .i_drain_cycles(dly),
      .o_pipe_drained(drained));

   // Free-running system clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic results();
      if (failures == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results

   task automatic chk(input logic [DATA_W-1:0] got,
      input logic [DATA_W-1:0] e);
      tests_run++;
      if (got !== e)
      begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, e);
      end
   endtask : chk

   task automatic chk_b(input logic got, input logic e);
      chk({63'h0, got}, {63'h0, e});
   endtask : chk_b

   task automatic wr_reg(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : wr_reg

   task automatic rd_chk(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk_b(rvld, 1'b1);
      chk(rdata, e);
   endtask : rd_chk

   // One run-control write, its pulses judged against the model
   task automatic op(input int c);
      logic [DATA_W-1:0] d;
      d = {$urandom, $urandom};
      d[1:0] = 2'(c);
      wr_reg(RUN_CTRL_OFS, d);
      chk_b(crst, 1'(c == 2));
      chk_b(drst, 1'(c == 3 && op_m != 3));
      chk_b(pcld, 1'(c == 1 && boot_m));
      if (c == 1 || c == 2)
         boot_m = 0;
      op_m = c;
      rd_chk(RUN_CTRL_OFS, 64'(op_m));
   endtask : op

   // Bounded wait for suspension after a halt
   task automatic wait_halt();
      int n = 0;
      while (halted !== 1'b1 && n < 40)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk_b(halted, 1'b1);
      chk_b(drained, 1'b1);
   endtask : wait_halt

   task automatic clear_int();
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      #1;
      chk_b(ireq, 1'b0);
   endtask : clear_int

   // Watchdog, far beyond the few hundred cycles the run needs
   initial
   begin
      #500000;
      failures++;
      results();
   end

   initial
   begin
      rst = 1'b1;
      {wr, rd, boot, vsel, sleep, blk, clr} = 7'h0;
      addr = '0;
      wdata = '0;
      vaddr = '0;
      failures = 0;
      tests_run = 0;
      op_m = 1;
      boot_m = 0;
      dly = 4'($urandom(60));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd_chk(RUN_CTRL_OFS, 64'(op_m));
      rd_chk(DBG_FORCE_OFS, 64'h0);
      rd_chk(24'h104008, 64'h0);
      // Every code, repeats and halts with varied drain times
      for (int r = 0; r < 3; r++)
      begin
         @(posedge clk);
         dly <= 4'($urandom_range(0, 7));
         op(0);
         chk_b(fstop, 1'b1);
         wait_halt();
         op(0);
         chk_b(halted, 1'b1);
         op(2);
         op(2);
         op(3);
         op(3);
         op(1);
         chk_b(halted, 1'b0);
         chk_b(fstop, 1'b0);
         op(1);
      end
      // Vector changes while suspended need a core reset
      @(posedge clk);
      v_old = {$urandom, $urandom};
      vaddr <= v_old;
      vsel <= 1'b0;
      repeat (2) @(posedge clk);
      op(0);
      wait_halt();
      @(posedge clk);
      vaddr <= {$urandom, $urandom};
      vsel <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk(ovaddr, v_old);
      chk_b(ovsel, 1'b0);
      op(2);
      chk(ovaddr, vaddr);
      chk_b(ovsel, 1'b1);
      op(1);
      // Forced debug interrupt: set, repeat, clear, zero write
      wr_reg(DBG_FORCE_OFS, 64'h1);
      chk_b(cause, 1'b1);
      chk_b(ireq, 1'b1);
      chk(64'(prio), 64'd16);
      wr_reg(DBG_FORCE_OFS, 64'h1);
      chk_b(cause, 1'b0);
      clear_int();
      wr_reg(DBG_FORCE_OFS, 64'hffff_ffff_ffff_fffe);
      chk_b(cause, 1'b0);
      chk_b(ireq, 1'b0);
      // Sleeping core is woken before the launch; inputs move on edges
      @(posedge clk);
      sleep <= 1'b1;
      wr_reg(DBG_FORCE_OFS, 64'h1);
      chk_b(wake, 1'b1);
      chk_b(ireq, 1'b0);
      @(posedge clk);
      sleep <= 1'b0;
      @(posedge clk);
      #1;
      chk_b(ireq, 1'b1);
      chk_b(wake, 1'b0);
      clear_int();
      // Blockable although above every mask level
      @(posedge clk);
      blk <= 1'b1;
      wr_reg(DBG_FORCE_OFS, 64'h1);
      chk_b(cause, 1'b1);
      chk_b(ireq, 1'b0);
      chk_b(wake, 1'b0);
      @(posedge clk);
      blk <= 1'b0;
      @(posedge clk);
      #1;
      chk_b(ireq, 1'b1);
      clear_int();
      // Boot straight into suspension, then resume at zero
      @(posedge clk);
      boot <= 1'b1;
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      op_m = 1;
      boot_m = 1;
      repeat (3) @(posedge clk);
      #1;
      chk_b(halted, 1'b1);
      op(1);
      chk(rpc, 64'h0);
      results();
   end
endmodule : cpu_run_control_debug_int_bench
